// file: src/cfx_exec.sv
// Purpose: Executes call, invert, decrement, clear-file and clear-working
// Assumes: File read data is combinational for the addressed file register
// Notes: All outputs registered except file_rd_addr, taken from instr; one instruction accepted per free cycle
`timescale 1ns/1ps
`include "cfx_map.svh"
module cfx_exec
	import cfx_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [13:0] instr,
	input wire logic [7:0] pc_high_latch,
	input wire logic [7:0] file_rd_data,
	output logic [6:0] file_rd_addr,
	output logic [`CFX_PC_W-1:0] pc_q,
	output cfx_push_t stack_top_q,
	output cfx_file_wr_t file_wr_q,
	output logic [7:0] accum_q,
	output logic accum_wr_q,
	output logic zero_flag_q,
	output logic zero_wr_q,
	output logic busy_q
);
	// ************
	// Decode
	// ************
	typedef enum {ST_RUN, ST_NOP} cfx_state_t;
	cfx_state_t state_q, state_d;
	cfx_kind_t kind;
	logic [`CFX_PC_W-1:0] pc_d;
	cfx_push_t stack_top_d;
	cfx_file_wr_t file_wr_d;
	logic [7:0] accum_d, result;
	logic accum_wr_d, zero_flag_d, zero_wr_d, busy_d, dest;

	function automatic cfx_kind_t decode(input logic [13:0] w);
		if (w[13:11] == 3'(`CFX_CALL_OP >> 1) && w[11] == 1'b0)
			return CFX_CALL;
		else if (w[13:8] == `CFX_INV_OP)
			return CFX_INV;
		else if (w[13:8] == `CFX_DEC_OP)
			return CFX_DEC;
		else if (w[13:8] == `CFX_CLR_OP && w[7])
			return CFX_ZERO_FILE_OP;
		else if (w[13:8] == `CFX_CLR_OP)
			return CFX_ZERO_ACCUMULATOR_OP;
		return CFX_NONE;
	endfunction

	assign file_rd_addr = instr[6:0];
	assign dest = instr[`CFX_DEST_BIT];

	// ************
	// Next state
	// ************
	always_comb begin
		state_d = ST_RUN;
		pc_d = pc_q;
		stack_top_d = '0;
		file_wr_d = '0;
		accum_d = accum_q;
		accum_wr_d = 1'b0;
		zero_flag_d = zero_flag_q;
		zero_wr_d = 1'b0;
		busy_d = 1'b0;
		result = 8'h00;
		kind = instr_valid ? decode(instr) : CFX_NONE;
		case (state_q)
			ST_NOP: begin
				state_d = ST_RUN;
			end
			ST_RUN: begin
				case (kind)
					CFX_CALL: begin
						stack_top_d.valid = 1'b1;
						stack_top_d.addr = pc_q + 13'h0001;
						pc_d[`CFX_IMM_W-1:0] = instr[10:0];
						pc_d[12:11] = pc_high_latch[4:3];
						state_d = ST_NOP;
						busy_d = 1'b1;
					end
					CFX_INV, CFX_DEC: begin
						if (kind == CFX_INV)
							result = ~file_rd_data;
						else
							result = file_rd_data - 8'h01;
						zero_flag_d = (result == 8'h00);
						zero_wr_d = 1'b1;
						if (dest) begin
							file_wr_d.valid = 1'b1;
							file_wr_d.addr = instr[6:0];
							file_wr_d.data = result;
						end else begin
							accum_d = result;
							accum_wr_d = 1'b1;
						end
						pc_d = pc_q + 13'h0001;
					end
					CFX_ZERO_FILE_OP: begin
						file_wr_d.valid = 1'b1;
						file_wr_d.addr = instr[6:0];
						file_wr_d.data = 8'h00;
						zero_flag_d = 1'b1;
						zero_wr_d = 1'b1;
						pc_d = pc_q + 13'h0001;
					end
					CFX_ZERO_ACCUMULATOR_OP: begin
						accum_d = 8'h00;
						accum_wr_d = 1'b1;
						zero_flag_d = 1'b1;
						zero_wr_d = 1'b1;
						pc_d = pc_q + 13'h0001;
					end
					default: begin
						if (instr_valid)
							pc_d = pc_q + 13'h0001;
					end
				endcase
			end
			default: state_d = ST_RUN;
		endcase
	end

	// ************
	// Registers
	// ************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_RUN;
			pc_q <= `CFX_PC_RST;
			stack_top_q <= '0;
			file_wr_q <= '0;
			accum_q <= 8'h00;
			accum_wr_q <= 1'b0;
			zero_flag_q <= 1'b0;
			zero_wr_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pc_q <= pc_d;
			stack_top_q <= stack_top_d;
			file_wr_q <= file_wr_d;
			accum_q <= accum_d;
			accum_wr_q <= accum_wr_d;
			zero_flag_q <= zero_flag_d;
			zero_wr_q <= zero_wr_d;
			busy_q <= busy_d;
		end
	end

	// ************
	// Checks
	// ************
	property p_call_push;
		@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN && instr_valid && decode(instr) == CFX_CALL) |=>
		stack_top_q.valid && stack_top_q.addr == $past(pc_q) + 13'h0001;
	endproperty
	a_call_push: assert property (p_call_push)
		else $error("Call pushed wrong return address");
	property p_call_low;
		@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN && instr_valid && decode(instr) == CFX_CALL) |=>
		pc_q[10:0] == $past(instr[10:0]);
	endproperty
	a_call_low: assert property (p_call_low)
		else $error("Call low target wrong");
	property p_call_high;
		@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN && instr_valid && decode(instr) == CFX_CALL) |=>
		pc_q[12:11] == $past(pc_high_latch[4:3]);
	endproperty
	a_call_high: assert property (p_call_high)
		else $error("Call high target wrong");
	property p_call_two;
		@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN && instr_valid && decode(instr) == CFX_CALL) |=>
		busy_q && !zero_wr_q && $stable(zero_flag_q) ##1 !zero_wr_q
		&& !file_wr_q.valid && $stable(pc_q)
		&& $stable(zero_flag_q);
	endproperty
	a_call_two: assert property (p_call_two)
		else $error("Call not two cycles or touched flags");
	property p_inv;
		@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN && instr_valid && decode(instr) == CFX_INV
		&& instr[7]) |=> file_wr_q.valid && file_wr_q.data == ~$past(file_rd_data);
	endproperty
	a_inv: assert property (p_inv)
		else $error("Invert result wrong");
	property p_dest_w;
		@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN && instr_valid && decode(instr) == CFX_DEC
		&& !instr[7]) |=> accum_wr_q && !file_wr_q.valid
		&& accum_q == $past(file_rd_data) - 8'h01;
	endproperty
	a_dest_w: assert property (p_dest_w)
		else $error("Decrement to working register wrong");
	property p_zero_file_op;
		@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN && instr_valid && decode(instr) == CFX_ZERO_FILE_OP) |=>
		file_wr_q.valid && file_wr_q.data == 8'h00 && zero_flag_q;
	endproperty
	a_zero_file_op: assert property (p_zero_file_op)
		else $error("Clear file wrong");
	property p_zero_accumulator_op;
		@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN && instr_valid && decode(instr) == CFX_ZERO_ACCUMULATOR_OP) |=>
		accum_q == 8'h00 && zero_flag_q && !file_wr_q.valid;
	endproperty
	a_zero_accumulator_op: assert property (p_zero_accumulator_op)
		else $error("Clear working register wrong");
	property p_zero;
		@(posedge core_clk) disable iff (rst)
		zero_wr_q && (file_wr_q.valid || accum_wr_q) |->
		zero_flag_q == ((file_wr_q.valid ? file_wr_q.data : accum_q) == 8'h00);
	endproperty
	a_zero: assert property (p_zero)
		else $error("Zero flag disagrees with result");
endmodule

// file: common/cfx_map.svh
// Purpose: Constants for the call and file-operation execute block
// Assumes: 14-bit instruction words, 13-bit program counter
// Notes: Included by the package and the execute module
// How it works
// - A call pushes the current program counter plus one onto the stack.
// - A call loads the 11-bit immediate into program counter bits 10:0.
// - A call copies latch bits 4:3 into program counter bits 12:11.
// - A call takes two cycles and changes no status flag.
// - Invert takes the complement of the file register and updates zero.
// - Destination bit 0 writes the working register, 1 the file register.
// - Decrement subtracts one from the file register and updates zero.
// - Clear-file writes zero to the file register and sets zero.
// - Clear-working loads zero into the working register and sets zero.
// - A program counter change costs a second cycle run as no-operation.
`ifndef CFX_MAP_SVH
`define CFX_MAP_SVH
`define CFX_PC_W 13
`define CFX_IMM_W 11
`define CFX_PC_RST 13'h0000
`define CFX_LATCH_LO 3
`define CFX_LATCH_HI 4
`define CFX_DEST_BIT 7
`define CFX_CALL_OP 4'h8
`define CFX_INV_OP 6'h09
`define CFX_DEC_OP 6'h03
`define CFX_CLR_OP 6'h01
`endif

// file: common/cfx_pkg.sv
// Purpose: Types for the call and file-operation execute block
// Assumes: Constants come from cfx_map.svh
// Notes: None
`include "cfx_map.svh"
package cfx_pkg;
	typedef enum logic [2:0] {
		CFX_NONE, CFX_CALL, CFX_INV, CFX_DEC, CFX_ZERO_FILE_OP, CFX_ZERO_ACCUMULATOR_OP
	} cfx_kind_t;
	typedef struct packed {
		logic valid;
		logic [6:0] addr;
		logic [7:0] data;
	} cfx_file_wr_t;
	typedef struct packed {
		logic valid;
		logic [`CFX_PC_W-1:0] addr;
	} cfx_push_t;
endpackage

// file: testbench/cfx_prog_mem.sv
// Purpose: Program memory model that feeds instruction words
// Assumes: Word is read combinationally at the program counter
// Notes: Places never loaded read as zero
`timescale 1ns/1ps
`include "cfx_map.svh"
module cfx_prog_mem
	import cfx_pkg::*;
(
	input wire logic [`CFX_PC_W-1:0] pc,
	output logic [13:0] word
);
	logic [13:0] mem [0:8191];
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = 14'h0000;
		end
	end
	assign word = mem[pc];
endmodule

// file: testbench/call_and_file_op_execute_tb_top.sv
// Purpose: Self-checking bench for the execute block
// Assumes: Memory model supplies the word at the program counter
// Notes: Expected values are worked out here
`timescale 1ns/1ps
`include "cfx_map.svh"
module call_and_file_op_execute_tb_top
	import cfx_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic instr_valid = 1'b0;
	logic [7:0] pc_high_latch = 8'h00;
	logic [7:0] file_rd_data = 8'h00;
	logic [13:0] instr;
	logic [6:0] file_rd_addr;
	logic [`CFX_PC_W-1:0] pc_q;
	cfx_push_t stack_top_q;
	cfx_file_wr_t file_wr_q;
	logic [7:0] accum_q;
	logic accum_wr_q, zero_flag_q, zero_wr_q, busy_q;
	logic [12:0] exp_pc = 13'h0000;
	logic exp_z = 1'b0;
	int mismatches = 0;
	int compares = 0;
	cfx_prog_mem i_mem (.pc(pc_q), .word(instr));
	cfx_exec i_dut (.core_clk(core_clk), .rst(rst),
		.instr_valid(instr_valid), .instr(instr),
		.pc_high_latch(pc_high_latch), .file_rd_data(file_rd_data),
		.file_rd_addr(file_rd_addr), .pc_q(pc_q),
		.stack_top_q(stack_top_q), .file_wr_q(file_wr_q),
		.accum_q(accum_q), .accum_wr_q(accum_wr_q),
		.zero_flag_q(zero_flag_q), .zero_wr_q(zero_wr_q), .busy_q(busy_q));
	always #2.5 core_clk = ~core_clk;
	// ****************************************
	// Shared tasks
	// ****************************************
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task finish_test;
		if (mismatches == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task issue(input logic [13:0] w, input logic [7:0] rd,
		input logic [7:0] lt, input logic hold);
		@(posedge core_clk);
		i_mem.mem[pc_q] <= w;
		instr_valid <= 1'b1;
		file_rd_data <= rd;
		pc_high_latch <= lt;
		#1;
		if (!hold) chk(file_rd_addr, w[6:0]);
		@(posedge core_clk);
		if (!hold) begin
			instr_valid <= 1'b0;
		end
		#1;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task op(input logic [5:0] code, input logic d, input logic [6:0] f,
		input logic [7:0] rd, input logic [7:0] res, input logic z);
		issue({code, d, f}, rd, 8'h00, 1'b0);
		exp_pc = exp_pc + 13'h1;
		exp_z = z;
		chk(pc_q, exp_pc);
		chk(file_wr_q.valid, d);
		if (d) chk({file_wr_q.addr, file_wr_q.data}, {f, res});
		else chk(accum_q, res);
		chk(accum_wr_q, !d);
		chk({zero_wr_q, zero_flag_q}, {1'b1, z});
	endtask
	task do_call(input logic [10:0] k, input logic [7:0] lt);
		i_mem.mem[{lt[4:3], k}] = {6'h09, 1'b1, 7'h10};
		issue({3'b100, k}, 8'h00, lt, 1'b1);
		chk(stack_top_q, {1'b1, exp_pc + 13'h1});
		exp_pc = {lt[4:3], k};
		chk(pc_q, exp_pc);
		chk({zero_wr_q, zero_flag_q}, {1'b0, exp_z});
		chk({accum_wr_q, file_wr_q.valid}, 2'b00);
		chk(busy_q, 1'b1);
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
		chk({busy_q, stack_top_q.valid, file_wr_q.valid}, 3'b000);
		chk(pc_q, exp_pc);
	endtask
	task do_reset;
		@(posedge core_clk);
		rst <= 1'b1;
		#1;
		chk(pc_q, 13'h0000);
		chk(stack_top_q, 14'h0000);
		chk(file_wr_q, 16'h0000);
		chk({accum_q, accum_wr_q, zero_flag_q, zero_wr_q, busy_q}, 12'h000);
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		exp_pc = 13'h0000;
		exp_z = 1'b0;
		#1;
		chk(pc_q, exp_pc);
	endtask
	task do_other;
		issue(14'h3fff, 8'h00, 8'h00, 1'b0);
		exp_pc = exp_pc + 13'h1;
		chk(pc_q, exp_pc);
		chk(zero_flag_q, exp_z);
		chk({file_wr_q.valid, accum_wr_q, zero_wr_q}, 3'h0);
		chk({stack_top_q.valid, busy_q}, 2'h0);
	endtask
	initial begin
		#100000;
		mismatches++;
		finish_test;
	end
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		chk(pc_q, 13'h0000);
		op(6'h09, 1'b1, 7'h15, 8'hff, 8'h00, 1'b1);
		op(6'h09, 1'b0, 7'h7f, 8'h5a, 8'ha5, 1'b0);
		op(6'h03, 1'b1, 7'h00, 8'h01, 8'h00, 1'b1);
		op(6'h03, 1'b0, 7'h22, 8'h00, 8'hff, 1'b0);
		op(6'h01, 1'b1, 7'h40, 8'h77, 8'h00, 1'b1);
		do_call(11'h5a5, 8'h18);
		do_reset;
		op(6'h01, 1'b0, 7'h33, 8'h12, 8'h00, 1'b1);
		op(6'h03, 1'b0, 7'h22, 8'h00, 8'hff, 1'b0);
		do_other;
		do_call(11'h7ff, 8'he7);
		finish_test;
	end
endmodule
